/* File: logic/monitor_consts.vh */
`ifndef MONITOR_CONSTS_VH
`define MONITOR_CONSTS_VH
// Register pointer offsets
`define OFS_STATUS_LOW 5'h00
`define OFS_STATUS_HIGH 5'h01
`define OFS_CTRL_PAIR_A 5'h06
`define OFS_CTRL_PAIR_B 5'h07
`define OFS_DUTY_THR_LOW 5'h08
`define OFS_DUTY_THR_HIGH 5'h09
`define OFS_RESULT_FIRST 5'h0a
`define OFS_RESULT_LAST 5'h1d
`define PTR_LAST 5'h1f
// Result slots: 0..7 inputs, 8 internal temperature, 9 supply
`define SLOT_CH7 4'h6
`define SLOT_TINT 4'h8
`define SLOT_SUPPLY 4'h9
`define SLOT_NONE 4'hf
`define NUM_SLOTS 10
// Control bit positions
`define BIT_FILT_LO_PAIR 3
`define BIT_FILT_HI_PAIR 7
`define BIT_KELVIN_PAIR_B 6
`define BIT_FILT_TINT 3
`define BIT_DUTY_INV 5
`define BIT_DUTY_EN 6
`define BIT_THR0 7
// Result scaling, microvolts per code, and supply offset in volts
`define SE_UV_PER_CODE 305.18
`define DIFF_UV_PER_CODE 19.075
`define SUPPLY_OFFSET_V 2.5
// Pulse output timing
`define CLK_MHZ 250
`define DUTY_PERIOD_US 1000
`define DUTY_STEPS 512
`define DUTY_STEP_CYC ((`DUTY_PERIOD_US * `CLK_MHZ) / `DUTY_STEPS)
`define THR_SHIFT 4
`endif

/* File: logic/duty_gen.v */
`include "monitor_consts.vh"

module duty_gen #(
  parameter STEP_CYC = `DUTY_STEP_CYC
) (
  input wire clk,
  input wire rst_b,
  input wire [12:0] temp,
  input wire [8:0] thr,
  input wire kelvin,
  input wire enable,
  input wire invert,
  output reg pwm
);
  reg [9:0] step_cnt;
  reg [8:0] phase;
  reg [9:0] duty;
  reg [9:0] next_duty;
  reg signed [14:0] diff;
  reg [14:0] t_ext;
  reg [14:0] th_ext;
  wire step = (step_cnt == STEP_CYC[9:0] - 10'h001);

  always @* begin
    // Celsius codes are two's complement, Kelvin codes never negative
    t_ext = kelvin ? {2'b00, temp} : {{2{temp[12]}}, temp};
    th_ext = kelvin ? {2'b00, thr, 4'h0} : {{2{thr[8]}}, thr, 4'h0};
    diff = $signed(t_ext - th_ext);
    if (diff < 0) begin
      next_duty = 10'h000;
    end else if (diff >= 15'sd512) begin
      next_duty = 10'h200;
    end else begin
      next_duty = {1'b0, diff[8:0]};
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      step_cnt <= 10'h000;
      phase <= 9'h000;
      duty <= 10'h000;
      pwm <= 1'b0;
    end else begin
      step_cnt <= step ? 10'h000 : step_cnt + 10'h001;
      if (step) begin
        phase <= phase + 9'h001;
        // Duty only changes at a period boundary so no runt pulses appear
        if (phase == 9'h1ff) begin
          duty <= next_duty;
        end
      end
      if (!enable) begin
        pwm <= 1'b0;
      end else begin
        pwm <= ({1'b0, phase} < duty) ^ invert;
      end
    end
  end
endmodule // duty_gen

/* File: logic/monitor_backend.v */
`include "monitor_consts.vh"

module monitor_backend #(
  parameter [6:0] SLAVE_ADDR = 7'h48,
  parameter STEP_CYC = `DUTY_STEP_CYC
) (
  // Clock and reset
  input wire CLK_IN,
  input wire RST_B_IN,
  // Two-wire serial link
  input wire SCL_IN,
  input wire SDA_IN,
  output reg SDA_OUT,
  output reg SDA_OE_B_OUT,
  // Measurement sequencer
  input wire RES_WR_IN,
  input wire [3:0] RES_SLOT_IN,
  input wire [13:0] RES_DATA_IN,
  output reg RES_READY_OUT,
  // Pulse output
  output wire DUTY_PWM_OUT
);
  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_ADDR = 9'h002;
  localparam [8:0] S_ACKA = 9'h004;
  localparam [8:0] S_CMD = 9'h008;
  localparam [8:0] S_ACKC = 9'h010;
  localparam [8:0] S_WR = 9'h020;
  localparam [8:0] S_ACKW = 9'h040;
  localparam [8:0] S_RD = 9'h080;
  localparam [8:0] S_ACKR = 9'h100;

  reg [2:0] scl_sync;
  reg [2:0] sda_sync;
  reg scl_f;
  reg sda_f;
  reg scl_d;
  reg sda_d;
  reg [8:0] state;
  reg [3:0] cnt;
  reg [7:0] sh;
  reg [7:0] tx;
  reg rw;
  reg mack;
  reg [4:0] ptr;
  reg read_active;
  reg [5:0] stat_hi;
  reg [7:0] ctrl_a;
  reg [7:0] ctrl_b;
  reg [7:0] thr_low;
  reg [7:0] thr_high;
  reg [13:0] res [0:`NUM_SLOTS-1];
  reg [`NUM_SLOTS-1:0] valid;
  reg [`NUM_SLOTS-1:0] next_valid;
  reg [3:0] clr_slot;
  reg [17:0] filt_sum;
  reg [13:0] new_val;
  reg [7:0] rdata;
  reg [3:0] rslot;
  integer i;

  wire start_ev = scl_f && scl_d && sda_d && !sda_f;
  wire stop_ev = scl_f && scl_d && !sda_d && sda_f;
  wire scl_rise = scl_f && !scl_d;
  wire scl_fall = !scl_f && scl_d;

  // Map a register pointer to the result slot it belongs to
  function [3:0] slot_of;
    input [4:0] p;
    reg [4:0] off;
    begin
      off = p - `OFS_RESULT_FIRST;
      if (p >= `OFS_RESULT_FIRST && p <= `OFS_RESULT_LAST) begin
        slot_of = off[4:1];
      end else begin
        slot_of = `SLOT_NONE;
      end
    end
  endfunction

  // Filter enable per slot
  function filt_on;
    input [3:0] s;
    begin
      if (s == `SLOT_SUPPLY) begin
        filt_on = 1'b0;
      end else if (s == `SLOT_TINT) begin
        filt_on = thr_low[`BIT_FILT_TINT];
      end else if (s[2]) begin
        filt_on = s[1] ? ctrl_b[`BIT_FILT_HI_PAIR] : ctrl_b[`BIT_FILT_LO_PAIR];
      end else begin
        filt_on = s[1] ? ctrl_a[`BIT_FILT_HI_PAIR] : ctrl_a[`BIT_FILT_LO_PAIR];
      end
    end
  endfunction

  // Three-stage sampling; a change counts when the last two stages agree
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], SCL_IN};
      sda_sync <= {sda_sync[1:0], SDA_IN};
      if (scl_sync[1] == scl_sync[2]) begin
        scl_f <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_f <= sda_sync[2];
      end
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  // Read data multiplexer
  always @* begin
    rslot = slot_of(ptr);
    rdata = 8'h00;
    if (ptr == `OFS_STATUS_LOW) begin
      rdata = valid[7:0];
    end else if (ptr == `OFS_STATUS_HIGH) begin
      rdata = {stat_hi, valid[`SLOT_TINT], valid[`SLOT_SUPPLY]};
    end else if (ptr == `OFS_CTRL_PAIR_A) begin
      rdata = ctrl_a;
    end else if (ptr == `OFS_CTRL_PAIR_B) begin
      rdata = ctrl_b;
    end else if (ptr == `OFS_DUTY_THR_LOW) begin
      rdata = thr_low;
    end else if (ptr == `OFS_DUTY_THR_HIGH) begin
      rdata = thr_high;
    end else if (rslot != `SLOT_NONE) begin
      if (!ptr[0]) begin
        rdata = {valid[rslot], res[rslot][13], res[rslot][13:8]};
      end else begin
        rdata = res[rslot][7:0];
      end
    end
  end

  // Filter: 15 * old + sample, over 16, old taken from the register itself
  always @* begin
    filt_sum = ({{4{res[RES_SLOT_IN][13]}}, res[RES_SLOT_IN]} <<< 4)
      - {{4{res[RES_SLOT_IN][13]}}, res[RES_SLOT_IN]}
      + {{4{RES_DATA_IN[13]}}, RES_DATA_IN};
    // Codes pass through unscaled; the weight per code is fixed by the converter
    if (filt_on(RES_SLOT_IN)) begin
      new_val = filt_sum[17:4];
    end else begin
      new_val = RES_DATA_IN;
    end
  end

  always @* begin
    next_valid = valid;
    if (clr_slot != `SLOT_NONE) begin
      next_valid[clr_slot] = 1'b0;
    end
    // A fresh result in the same cycle as an access still counts as fresh
    if (RES_WR_IN && RES_READY_OUT && RES_SLOT_IN < `NUM_SLOTS) begin
      next_valid[RES_SLOT_IN] = 1'b1;
    end
  end

  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      valid <= {`NUM_SLOTS{1'b0}};
      for (i = 0; i < `NUM_SLOTS; i = i + 1) begin
        res[i] <= 14'h0000;
      end
    end else begin
      valid <= next_valid;
      if (RES_WR_IN && RES_READY_OUT && RES_SLOT_IN < `NUM_SLOTS) begin
        res[RES_SLOT_IN] <= new_val;
      end
    end
  end

  // Serial slave
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state <= S_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      mack <= 1'b0;
      ptr <= 5'h00;
      read_active <= 1'b0;
      RES_READY_OUT <= 1'b1;
      SDA_OUT <= 1'b0;
      SDA_OE_B_OUT <= 1'b1;
      clr_slot <= `SLOT_NONE;
      stat_hi <= 6'h00;
      ctrl_a <= 8'h00;
      ctrl_b <= 8'h00;
      thr_low <= 8'h00;
      thr_high <= 8'h00;
    end else begin
      SDA_OUT <= 1'b0;
      clr_slot <= `SLOT_NONE;
      RES_READY_OUT <= !read_active;
      if (start_ev) begin
        state <= S_ADDR;
        cnt <= 4'h0;
        SDA_OE_B_OUT <= 1'b1;
        read_active <= 1'b0;
      end else if (stop_ev) begin
        state <= S_IDLE;
        SDA_OE_B_OUT <= 1'b1;
        read_active <= 1'b0;
      end else if (scl_rise) begin
        if (state == S_ADDR || state == S_CMD || state == S_WR) begin
          sh <= {sh[6:0], sda_f};
          cnt <= cnt + 4'h1;
        end else if (state == S_ACKR) begin
          mack <= !sda_f;
        end
      end else if (scl_fall) begin
        case (state)
          S_ADDR: begin
            if (cnt == 4'h8) begin
              if (sh[7:1] == SLAVE_ADDR) begin
                SDA_OE_B_OUT <= 1'b0;
                rw <= sh[0];
                state <= S_ACKA;
              end else begin
                state <= S_IDLE;
              end
            end
          end
          S_ACKA: begin
            if (rw) begin
              // Holds off the sequencer until the read ends
              read_active <= 1'b1;
              tx <= rdata;
              SDA_OE_B_OUT <= rdata[7];
              cnt <= 4'h1;
              state <= S_RD;
            end else begin
              SDA_OE_B_OUT <= 1'b1;
              cnt <= 4'h0;
              state <= S_CMD;
            end
          end
          S_CMD: begin
            if (cnt == 4'h8) begin
              ptr <= sh[4:0];
              clr_slot <= slot_of(sh[4:0]);
              SDA_OE_B_OUT <= 1'b0;
              state <= S_ACKC;
            end
          end
          S_ACKC, S_ACKW: begin
            SDA_OE_B_OUT <= 1'b1;
            cnt <= 4'h0;
            state <= S_WR;
          end
          S_WR: begin
            if (cnt == 4'h8) begin
              if (ptr == `OFS_STATUS_HIGH) begin
                stat_hi <= sh[7:2];
              end else if (ptr == `OFS_CTRL_PAIR_A) begin
                ctrl_a <= sh;
              end else if (ptr == `OFS_CTRL_PAIR_B) begin
                ctrl_b <= sh;
              end else if (ptr == `OFS_DUTY_THR_LOW) begin
                thr_low <= sh;
              end else if (ptr == `OFS_DUTY_THR_HIGH) begin
                thr_high <= sh;
              end
              ptr <= ptr + 5'h01;
              SDA_OE_B_OUT <= 1'b0;
              state <= S_ACKW;
            end
          end
          S_RD: begin
            if (cnt == 4'h8) begin
              SDA_OE_B_OUT <= 1'b1;
              clr_slot <= rslot;
              ptr <= (ptr == `PTR_LAST) ? 5'h00 : ptr + 5'h01;
              state <= S_ACKR;
            end else begin
              tx <= {tx[6:0], 1'b0};
              SDA_OE_B_OUT <= tx[6];
              cnt <= cnt + 4'h1;
            end
          end
          S_ACKR: begin
            if (mack) begin
              tx <= rdata;
              SDA_OE_B_OUT <= rdata[7];
              cnt <= 4'h1;
              state <= S_RD;
            end else begin
              read_active <= 1'b0;
              state <= S_IDLE;
            end
          end
          default: begin
            state <= state;
          end
        endcase
      end
    end
  end

  // Stored channel seven value is already filtered when its pair filters
  duty_gen #(
    .STEP_CYC(STEP_CYC)
  ) u_duty (
    .clk(CLK_IN),
    .rst_b(RST_B_IN),
    .temp(res[`SLOT_CH7][12:0]),
    .thr({thr_high, thr_low[`BIT_THR0]}),
    .kelvin(ctrl_b[`BIT_KELVIN_PAIR_B]),
    .enable(thr_low[`BIT_DUTY_EN]),
    .invert(thr_low[`BIT_DUTY_INV]),
    .pwm(DUTY_PWM_OUT)
  );
endmodule // monitor_backend

/* File: tb/monitor_properties.sv */
module monitor_properties #(parameter STEP_CYC = 2) (
  // Clock and reset
  input wire CLK_IN,
  input wire RST_B_IN,
  // Serial link
  input wire SCL_IN,
  input wire SDA_IN,
  input wire SDA_OUT,
  input wire SDA_OE_B_OUT,
  // Sequencer and pulse
  input wire RES_READY_OUT,
  input wire DUTY_PWM_OUT
);
  localparam int PER = 512 * STEP_CYC;
  logic pwm_q;
  logic seen;
  logic [31:0] run;
  // Rises are only judged once a first rise has fixed the period phase
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      pwm_q <= 1'b0;
      seen <= 1'b0;
      run <= 32'h0;
    end else begin
      pwm_q <= DUTY_PWM_OUT;
      if (DUTY_PWM_OUT && !pwm_q) begin
        seen <= 1'b1;
        run <= 32'h0;
      end else begin
        run <= run + 32'h1;
      end
    end
  end
  default clocking cb @(posedge CLK_IN); endclocking
  sequence stop_seen;
    SCL_IN && $past(SCL_IN) && $rose(SDA_IN);
  endsequence
  sequence scl_settled;
    SCL_IN [*8];
  endsequence
  chk_sda_out_zero: assert property (disable iff (!RST_B_IN) SDA_OUT == 1'b0)
    else $error("data output value not zero");
  chk_reset_idle: assert property (!RST_B_IN |-> SDA_OE_B_OUT && RES_READY_OUT && !DUTY_PWM_OUT)
    else $error("outputs not idle in reset");
  chk_oe_scl_low: assert property (disable iff (!RST_B_IN) $changed(SDA_OE_B_OUT) |-> !$past(SCL_IN, 3))
    else $error("data line moved while clock high");
  chk_oe_settled: assert property (disable iff (!RST_B_IN) scl_settled |-> $stable(SDA_OE_B_OUT))
    else $error("data line moved late in clock high");
  chk_ready_stop: assert property (disable iff (!RST_B_IN) stop_seen |-> ##[1:12] RES_READY_OUT)
    else $error("sequencer not resumed after stop");
  chk_pwm_period: assert property (disable iff (!RST_B_IN) DUTY_PWM_OUT && !pwm_q && seen |-> ((run + 1) % PER) == 0)
    else $error("pulse rise off period grid");
  chk_ack_stands: assert property (disable iff (!RST_B_IN) $fell(SDA_OE_B_OUT) |-> !SDA_OE_B_OUT [*8])
    else $error("pull low too short");
  chk_release_stands: assert property (disable iff (!RST_B_IN) $rose(SDA_OE_B_OUT) |-> SDA_OE_B_OUT [*8])
    else $error("release too short");
endmodule // monitor_properties

/* File: tb/serial_master_model.sv */
module serial_master_model (
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_rel_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock stands high between frames; all edges land on falling system clock
  initial begin
    scl_out = 1'b1;
    sda_rel_out = 1'b1;
  end
  task automatic bit_slot(input logic b, output logic r);
    sda_rel_out = b;
    #12;
    scl_out = 1'b1;
    #20;
    r = sda_in;
    #4;
    scl_out = 1'b0;
    #12;
  endtask
  task automatic start_cond();
    sda_rel_out = 1'b1;
    #24;
    scl_out = 1'b1;
    #12;
    sda_rel_out = 1'b0;
    #12;
    scl_out = 1'b0;
    #12;
  endtask
  task automatic stop_cond();
    sda_rel_out = 1'b0;
    #12;
    scl_out = 1'b1;
    #12;
    sda_rel_out = 1'b1;
    #24;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(b[i], r);
    bit_slot(1'b1, r);
    ack = !r;
  endtask
  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, b[i]);
    bit_slot(!ack, r);
  endtask
endmodule // serial_master_model

/* File: tb/monitor_result_pwm_filter_i2c_test.sv */
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", what, exp, got); end end
module monitor_result_pwm_filter_i2c_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 2;
  localparam int PER = 512 * STEP;
  logic clk = 1'b0;
  logic rst_b = 1'b1;
  logic res_wr = 1'b0;
  logic [3:0] res_slot = 4'h0;
  logic [13:0] res_data = 14'h0;
  logic ack;
  logic [15:0] rd;
  wire scl;
  wire sda_rel;
  wire sda_oe_b;
  wire sda_out;
  wire res_ready;
  wire pwm;
  // Pull-up: the wire is high unless someone pulls it
  wire sda_wire = sda_rel & sda_oe_b;
  int n_errors = 0;
  int samples_checked = 0;
  logic [7:0] c08 [7] = '{8'h40, 8'h40, 8'hc0, 8'h40, 8'h60, 8'h60, 8'h00};
  logic [7:0] c09 [7] = '{8'h08, 8'h08, 8'hff, 8'h08, 8'h08, 8'h08, 8'h08};
  logic [13:0] t7 [7] = '{14'h0200, 14'h00ff, 14'h00f0, 14'h0300, 14'h0300, 14'h00ff,
    14'h0300};
  int hi [7] = '{PER / 2, 0, PER / 2, PER, 0, PER, 0};
  always #2 clk = ~clk;
  serial_master_model serial_master_model_i (.sda_in(sda_wire), .scl_out(scl),
    .sda_rel_out(sda_rel));
  monitor_backend #(.STEP_CYC(STEP)) monitor_backend_i (.CLK_IN(clk), .RST_B_IN(rst_b),
    .SCL_IN(scl), .SDA_IN(sda_wire), .SDA_OUT(sda_out), .SDA_OE_B_OUT(sda_oe_b),
    .RES_WR_IN(res_wr), .RES_SLOT_IN(res_slot), .RES_DATA_IN(res_data),
    .RES_READY_OUT(res_ready), .DUTY_PWM_OUT(pwm));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic reg_write(input logic [4:0] p, input logic [7:0] d0, input logic [7:0] d1,
      input bit two);
    serial_master_model_i.start_cond();
    serial_master_model_i.send_byte(8'h90, ack);
    serial_master_model_i.send_byte({3'h0, p}, ack);
    serial_master_model_i.send_byte(d0, ack);
    if (two) serial_master_model_i.send_byte(d1, ack);
    `CHK("write ack", 1'b1, ack)
    serial_master_model_i.stop_cond();
  endtask
  task automatic reg_read(input logic [4:0] p, input bit two, output logic [15:0] v);
    v = 16'h0;
    serial_master_model_i.start_cond();
    serial_master_model_i.send_byte(8'h90, ack);
    serial_master_model_i.send_byte({3'h0, p}, ack);
    serial_master_model_i.start_cond();
    serial_master_model_i.send_byte(8'h91, ack);
    `CHK("read ack", 1'b1, ack)
    serial_master_model_i.recv_byte(two, v[15:8]);
    if (two) serial_master_model_i.recv_byte(1'b0, v[7:0]);
    serial_master_model_i.stop_cond();
  endtask
  task automatic put_result(input logic [3:0] s, input logic [13:0] d);
    for (int i = 0; i < 1000 && res_ready !== 1'b1; i++) @(negedge clk);
    `CHK("sequencer ready", 1'b1, res_ready)
    @(negedge clk);
    res_wr = 1'b1;
    res_slot = s;
    res_data = d;
    @(negedge clk);
    res_wr = 1'b0;
    @(negedge clk);
  endtask
  // Duty is latched at period end, so let two periods settle before counting
  task automatic pwm_high(input int exp);
    int n;
    n = 0;
    repeat (2 * PER) @(negedge clk);
    repeat (PER) begin
      @(negedge clk);
      if (pwm === 1'b1) n++;
    end
    `CHK("pulse high count", exp, n)
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    `CHK("run time limit", 1'b0, 1'b1)
    tally_and_finish();
  end
  initial begin
    // A real falling edge, so the asynchronous reset is seen at start
    #1 rst_b = 1'b0;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    reg_read(5'h08, 1, rd);
    `CHK("threshold reset", 16'h0000, rd)
    reg_write(5'h08, 8'h80, 8'h5a, 1);
    reg_read(5'h08, 1, rd);
    `CHK("threshold word", 16'h805a, rd)
    serial_master_model_i.start_cond();
    serial_master_model_i.send_byte(8'ha0, ack);
    serial_master_model_i.stop_cond();
    `CHK("foreign address ack", 1'b0, ack)
    put_result(4'h0, 14'h2345);
    reg_read(5'h00, 0, rd);
    `CHK("status after result", 16'h0100, rd)
    // Pointing at the threshold leaves the result flag for the next byte to show
    reg_read(5'h09, 1, rd);
    `CHK("fresh bit set", 16'h5ae3, rd)
    reg_read(5'h0a, 1, rd);
    `CHK("result word", 16'h6345, rd & 16'h7fff)
    reg_read(5'h0a, 1, rd);
    `CHK("fresh bit cleared", 16'h6345, rd)
    reg_read(5'h00, 0, rd);
    `CHK("status cleared", 16'h0000, rd)
    put_result(4'h1, 14'h0001);
    reg_read(5'h1f, 1, rd);
    `CHK("byte after last", 8'h02, rd[7:0])
    // A write offered while the host reads must be dropped
    serial_master_model_i.start_cond();
    serial_master_model_i.send_byte(8'h90, ack);
    serial_master_model_i.send_byte(8'h0a, ack);
    serial_master_model_i.start_cond();
    serial_master_model_i.send_byte(8'h91, ack);
    serial_master_model_i.recv_byte(1'b1, rd[15:8]);
    `CHK("ready in read", 1'b0, res_ready)
    @(negedge clk);
    res_wr = 1'b1;
    res_slot = 4'h0;
    res_data = 14'h0777;
    @(negedge clk);
    res_wr = 1'b0;
    serial_master_model_i.recv_byte(1'b0, rd[7:0]);
    serial_master_model_i.stop_cond();
    reg_read(5'h0a, 1, rd);
    `CHK("result frozen", 16'h6345, rd & 16'h7fff)
    put_result(4'h6, 14'h0100);
    reg_write(5'h07, 8'h80, 8'h00, 0);
    put_result(4'h6, 14'h0200);
    reg_read(5'h16, 1, rd);
    `CHK("filtered result", 16'h0110, rd & 16'h7fff)
    reg_write(5'h06, 8'h88, 8'h88, 1);
    reg_write(5'h08, 8'h08, 8'h00, 0);
    put_result(4'h9, 14'h1000);
    put_result(4'h9, 14'h0010);
    reg_read(5'h1c, 1, rd);
    `CHK("supply result", 16'h0010, rd & 16'h7fff)
    reg_write(5'h06, 8'h00, 8'h00, 1);
    for (int k = 0; k < 7; k++) begin
      reg_write(5'h08, c08[k], c09[k], 1);
      put_result(4'h6, t7[k]);
      pwm_high(hi[k]);
    end
    tally_and_finish();
  end
endmodule // monitor_result_pwm_filter_i2c_test
bind monitor_backend monitor_properties #(.STEP_CYC(STEP_CYC)) monitor_properties_i (
  .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE_B_OUT(SDA_OE_B_OUT), .RES_READY_OUT(RES_READY_OUT), .DUTY_PWM_OUT(DUTY_PWM_OUT));
